/* dph_monitor.sv */
// pin-level assertions for the display panel host port
`timescale 1ns/1ps
module dph_monitor (
  input wire logic       clk_sys,
  input wire logic       rst,
  input wire logic       panel_reset_hold,
  input wire logic       req_valid,
  input wire logic       req_ready,
  input wire logic       resp_valid,
  input wire logic       panel_reset_n,
  input wire logic       panel_select_n,
  input wire logic       panel_serial_clock,
  input wire logic       panel_serial_out,
  input wire logic       write_strobe_n,
  input wire logic       read_strobe_n,
  input wire logic [7:0] par_data_out,
  input wire logic       par_data_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  AST_RESET_FOLLOW:
    assert property (!$past(rst) |-> panel_reset_n == !$past(panel_reset_hold))
    else $error("panel reset does not follow hold");
  AST_SCK_IDLE:
    assert property (panel_select_n |-> !panel_serial_clock)
    else $error("serial clock high while deselected");
  AST_SCK_HIGH_MIN:
    assert property ($rose(panel_serial_clock) |-> panel_serial_clock[*2])
    else $error("serial clock high phase too short");
  AST_SCK_LOW_MIN:
    assert property ($fell(panel_serial_clock) |-> !panel_serial_clock[*2])
    else $error("serial clock low phase too short");
  AST_SDO_ON_FALL:
    assert property (!panel_select_n && $past(!panel_select_n)
      && $changed(panel_serial_out) |-> $fell(panel_serial_clock))
    else $error("serial data changed away from a falling edge");
  AST_SEL_COVERS:
    assert property (!write_strobe_n || !read_strobe_n || panel_serial_clock
      |-> !panel_select_n)
    else $error("bus activity without chip select");
  AST_NO_MIX:
    assert property (!write_strobe_n || !read_strobe_n |-> !panel_serial_clock)
    else $error("serial and parallel activity mixed");
  AST_WR_LOW_MIN:
    assert property ($fell(write_strobe_n) |-> !write_strobe_n[*2])
    else $error("write strobe low too short");
  AST_WR_RISE:
    assert property ($rose(write_strobe_n) |-> par_data_oe
      && $stable(par_data_out) && !panel_select_n)
    else $error("write data not held to strobe rise");
  AST_RD_LOW_MIN:
    assert property ($fell(read_strobe_n) |-> !read_strobe_n[*4])
    else $error("read strobe low too short");
  AST_RD_RELEASED:
    assert property (!read_strobe_n |-> !par_data_oe)
    else $error("bus driven during read strobe");
  AST_TAKE:
    assert property (req_valid && req_ready |=> !req_ready && !panel_select_n)
    else $error("request not started on take");
  AST_RESP_END:
    assert property (resp_valid |-> $rose(panel_select_n))
    else $error("read answer not at end of transfer");

  cover property ($rose(panel_serial_clock));
  cover property ($fell(read_strobe_n));
  cover property (resp_valid);
  cover property ($rose(panel_reset_n));
endmodule

/* dph_panel_model.sv */
// behavioural display module on the far side of the port
`timescale 1ns/1ps
module dph_panel_model (
  input  wire logic        sck,
  input  wire logic        sel_n,
  input  wire logic        sdo,
  input  wire logic        dc,
  input  wire logic        rs,
  input  wire logic        wr_n,
  input  wire logic        rd_n,
  input  wire logic [7:0]  bus,
  input  wire logic [31:0] reply,
  output logic             sdi,
  output logic [7:0]       pdrv,
  output logic [7:0]       rx_byte,
  output logic             rx_dc,
  output logic [7:0]       p_byte,
  output logic             p_rs
);
  int n = 0;
  initial begin
    sdi = 1'b0;
    pdrv = 8'h00;
    rx_byte = 8'h00;
    rx_dc = 1'b0;
    p_byte = 8'h00;
    p_rs = 1'b0;
  end
  always @(negedge sel_n) n = 0;
  // first eight rising edges carry the byte, msb first
  always @(posedge sck) if (!sel_n) begin
    if (n < 8) rx_byte = {rx_byte[6:0], sdo};
    if (n == 7) rx_dc = dc;
    n = n + 1;
  end
  // reply bits change on falling edges, inverted when released
  always @(negedge sck or posedge sel_n)
    if (!sel_n && n >= 8 && n < 40) sdi = reply[39 - n];
    else sdi = ~sdi;
  always @(posedge wr_n) if (!sel_n) begin
    p_byte = bus;
    p_rs = rs;
  end
  always @(negedge rd_n or posedge rd_n)
    pdrv = !rd_n ? reply[7:0] : ~pdrv;
endmodule

/* dph_phase_timer.sv */
// down counter that times each bus phase
`timescale 1ns/1ps
module dph_phase_timer (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       load,
  input  wire logic [5:0] load_val,
  output logic            expired
);

  logic [5:0] cnt;
  logic [5:0] next_cnt;

  always_comb begin
    next_cnt = cnt;
    if (load) begin
      next_cnt = load_val;
    end else if (cnt != 6'h00) begin
      next_cnt = cnt - 6'h01;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt <= 6'h00;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign expired = (cnt == 6'h00);

endmodule

/* dph_pkg.sv */
// constants, types and timing for the display panel host port
package dph_pkg;

  localparam int SYS_CLK_NS        = 40;
  localparam int T_SCK_WR_CYCLE_NS = 100;
  localparam int T_SCK_WR_PHASE_NS = 40;
  localparam int T_SCK_RD_CYCLE_NS = 150;
  localparam int T_SCK_RD_PHASE_NS = 60;
  localparam int T_WR_LOW_NS       = 50;
  localparam int T_WR_HIGH_NS      = 50;
  localparam int T_WR_CYCLE_NS     = 100;
  localparam int T_RD_LOW_NS       = 150;
  localparam int T_RD_HIGH_NS      = 150;
  localparam int T_RD_CYCLE_NS     = 300;

  localparam int DATA_W = 8;
  localparam int RX_W   = 32;
  localparam int CNT_W  = 6;

  // least time to whole cycles, never below one
  function automatic int cyc_up(input int ns);
    int c;
    c = (ns + SYS_CLK_NS - 1) / SYS_CLK_NS;
    cyc_up = (c < 1) ? 1 : c;
  endfunction

  function automatic int max2(input int a, input int b);
    max2 = (a > b) ? a : b;
  endfunction

  localparam int SCK_WR_HALF_I = max2(cyc_up(T_SCK_WR_PHASE_NS),
                                      cyc_up((T_SCK_WR_CYCLE_NS + 1) / 2));
  localparam int SCK_RD_HALF_I = max2(cyc_up(T_SCK_RD_PHASE_NS),
                                      cyc_up((T_SCK_RD_CYCLE_NS + 1) / 2));
  localparam int WR_LOW_I  = cyc_up(T_WR_LOW_NS);
  localparam int WR_HIGH_I = max2(cyc_up(T_WR_HIGH_NS),
                                  cyc_up(T_WR_CYCLE_NS) - WR_LOW_I);
  localparam int RD_LOW_I  = cyc_up(T_RD_LOW_NS);
  localparam int RD_HIGH_I = max2(cyc_up(T_RD_HIGH_NS),
                                  cyc_up(T_RD_CYCLE_NS) - RD_LOW_I);

  localparam logic [CNT_W-1:0] SCK_WR_HALF_CYC = CNT_W'(SCK_WR_HALF_I);
  localparam logic [CNT_W-1:0] SCK_RD_HALF_CYC = CNT_W'(SCK_RD_HALF_I);
  localparam logic [CNT_W-1:0] WR_LOW_CYC      = CNT_W'(WR_LOW_I);
  localparam logic [CNT_W-1:0] WR_HIGH_CYC     = CNT_W'(WR_HIGH_I);
  localparam logic [CNT_W-1:0] RD_LOW_CYC      = CNT_W'(RD_LOW_I);
  localparam logic [CNT_W-1:0] RD_HIGH_CYC     = CNT_W'(RD_HIGH_I);

  localparam logic       RST_SCK      = 1'b0;
  localparam logic       RST_SEL_N    = 1'b1;
  localparam logic       RST_STROBE_N = 1'b1;
  localparam logic       RST_PANEL_N  = 1'b0;
  localparam logic [2:0] TX_LAST_IDX  = 3'h7;

  typedef enum logic [1:0] {
    DPH_OP_WRITE = 2'h0,
    DPH_OP_READ  = 2'h1
  } dph_op_t;

  typedef enum logic [1:0] {
    DPH_RLEN_8  = 2'h0,
    DPH_RLEN_24 = 2'h1,
    DPH_RLEN_32 = 2'h2
  } dph_rlen_t;

  typedef struct packed {
    dph_op_t             op;
    logic                is_data;
    dph_rlen_t           rlen;
    logic [DATA_W-1:0]   data;
  } dph_req_t;

  typedef enum logic [3:0] {
    ST_IDLE    = 4'h0,
    ST_S_LOW   = 4'h1,
    ST_S_HIGH  = 4'h2,
    ST_S_END   = 4'h3,
    ST_P_WLOW  = 4'h4,
    ST_P_WHIGH = 4'h5,
    ST_P_RLOW  = 4'h6,
    ST_P_RHIGH = 4'h7,
    ST_DONE    = 4'h8
  } dph_state_t;

  function automatic logic [CNT_W-1:0] rlen_bits(input dph_rlen_t r);
    case (r)
      DPH_RLEN_24: rlen_bits = 6'h18;
      DPH_RLEN_32: rlen_bits = 6'h20;
      default:     rlen_bits = 6'h08;
    endcase
  endfunction

endpackage

/* dph_top.sv */
// display panel host port: 4-wire serial or 8-bit parallel master
//
// What this block does
// - serial read starts by shifting the read command out on serial out
// - serial read clocks in exactly 8, 24 or 32 bits per command
// - serial write sends one 8-bit byte, msb first
// - device changes data on falling edge, panel samples on rising
// - start: select low, bit 7 shown before first rising edge
// - last data update places bit 0 and sets command/data select
// - command/data select low for command, high for parameter or pixel
// - messages span byte cycles; select may rise between bytes
// - serial write clock period at least 100 ns, phases at least 40 ns
// - serial read clock period at least 150 ns, phases at least 60 ns
// - parallel transfers use one 8-bit two-way data bus
// - active-low panel reset output, low holds panel in reset
// - register select low for index, high for memory or register data
// - active-low chip select asserted for every transfer
// - parallel write pulses write strobe low then high with data driven
// - write strobe low and high 50 ns each, cycle at least 100 ns
// - read strobe low and high 150 ns each, cycle at least 300 ns
// - parallel read: address write cycle first, then read strobe cycle
// - read strobe pulsed low, data taken at its rising edge
// - only one configuration active at a time, never mixed
`timescale 1ns/1ps
module dph_top (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             mode_parallel,
  input  wire logic             panel_reset_hold,
  input  wire logic [3:0]       phase_stretch,
  input  wire logic             req_valid,
  input  wire dph_pkg::dph_req_t req,
  output logic                  req_ready,
  output logic                  resp_valid,
  output logic [31:0]           resp_data,
  output logic                  panel_reset_n,
  output logic                  panel_select_n,
  output logic                  cmd_data_select,
  output logic                  panel_serial_clock,
  output logic                  panel_serial_out,
  input  wire logic             panel_serial_in,
  output logic                  register_select,
  output logic                  write_strobe_n,
  output logic                  read_strobe_n,
  input  wire logic [7:0]       par_data_in,
  output logic [7:0]            par_data_out,
  output logic                  par_data_oe
);

  dph_pkg::dph_state_t state;
  dph_pkg::dph_state_t next_state;
  dph_pkg::dph_op_t    op;
  dph_pkg::dph_op_t    next_op;
  logic                is_data;
  logic                next_is_data;
  logic [7:0]          tx_sh;
  logic [7:0]          next_tx_sh;
  logic [2:0]          tx_cnt;
  logic [2:0]          next_tx_cnt;
  logic                rx_mode;
  logic                next_rx_mode;
  logic [5:0]          rx_cnt;
  logic [5:0]          next_rx_cnt;
  logic [31:0]         rx_sh;
  logic [31:0]         next_rx_sh;
  logic                next_req_ready;
  logic                next_resp_valid;
  logic [31:0]         next_resp_data;
  logic                next_panel_reset_n;
  logic                next_sel_n;
  logic                next_dc;
  logic                next_sck;
  logic                next_sdo;
  logic                next_rs;
  logic                next_wr_n;
  logic                next_rd_n;
  logic [7:0]          next_pdo;
  logic                next_oe;
  logic                tmr_load;
  logic [5:0]          tmr_val;
  logic                tmr_expired;
  logic [8:0]          sync1;
  logic [8:0]          sync2;
  logic                sin_s;
  logic [7:0]          pdi_s;
  logic [5:0]          half_rd;
  logic [5:0]          half_wr;

  // pin inputs pass two flip-flops
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      sync1 <= 9'h000;
      sync2 <= 9'h000;
    end else begin
      sync1 <= {panel_serial_in, par_data_in};
      sync2 <= sync1;
    end
  end

  assign sin_s = sync2[8];
  assign pdi_s = sync2[7:0];

  // phase length minus one, widened by the stretch setting
  function automatic logic [5:0] phase_len(input logic [5:0] base,
                                           input logic [3:0] stretch);
    phase_len = base + {2'h0, stretch} - 6'h01;
  endfunction

  assign half_rd = phase_len(dph_pkg::SCK_RD_HALF_CYC, phase_stretch);
  assign half_wr = phase_len(dph_pkg::SCK_WR_HALF_CYC, phase_stretch);

  dph_phase_timer u_timer (
    .clk_sys  (clk_sys),
    .rst      (rst),
    .load     (tmr_load),
    .load_val (tmr_val),
    .expired  (tmr_expired)
  );

  always_comb begin
    next_state         = state;
    next_op            = op;
    next_is_data       = is_data;
    next_tx_sh         = tx_sh;
    next_tx_cnt        = tx_cnt;
    next_rx_mode       = rx_mode;
    next_rx_cnt        = rx_cnt;
    next_rx_sh         = rx_sh;
    next_resp_valid    = 1'b0;
    next_resp_data     = resp_data;
    next_panel_reset_n = ~panel_reset_hold;
    next_sel_n         = panel_select_n;
    next_dc            = cmd_data_select;
    next_sck           = panel_serial_clock;
    next_sdo           = panel_serial_out;
    next_rs            = register_select;
    next_wr_n          = write_strobe_n;
    next_rd_n          = read_strobe_n;
    next_pdo           = par_data_out;
    next_oe            = par_data_oe;
    tmr_load           = 1'b0;
    tmr_val            = 6'h00;
    case (state)
      dph_pkg::ST_IDLE: begin
        if (req_valid && req_ready) begin
          next_op       = req.op;
          next_is_data  = req.is_data;
          next_sel_n    = 1'b0;
          tmr_load      = 1'b1;
          if (mode_parallel) begin
            // read phase one writes the index with select low
            next_rs    = (req.op == dph_pkg::DPH_OP_READ) ? 1'b0
                                                        : req.is_data;
            next_pdo   = req.data;
            next_oe    = 1'b1;
            next_wr_n  = 1'b0;
            tmr_val    = phase_len(dph_pkg::WR_LOW_CYC, phase_stretch);
            next_state = dph_pkg::ST_P_WLOW;
          end else begin
            next_sck     = 1'b0;
            next_sdo     = req.data[7];
            next_tx_sh   = {req.data[6:0], 1'b0};
            next_tx_cnt  = dph_pkg::TX_LAST_IDX;
            // a read command is always a command byte
            next_dc      = (req.op == dph_pkg::DPH_OP_READ) ? 1'b0
                                                          : req.is_data;
            next_rx_mode = 1'b0;
            next_rx_sh   = 32'h0000_0000;
            next_rx_cnt  = dph_pkg::rlen_bits(req.rlen) - 6'h01;
            tmr_val      = (req.op == dph_pkg::DPH_OP_READ) ? half_rd
                                                          : half_wr;
            next_state   = dph_pkg::ST_S_LOW;
          end
        end
      end
      dph_pkg::ST_S_LOW: begin
        if (tmr_expired) begin
          next_sck   = 1'b1;
          tmr_load   = 1'b1;
          tmr_val    = (op == dph_pkg::DPH_OP_READ) ? half_rd : half_wr;
          next_state = dph_pkg::ST_S_HIGH;
        end
      end
      dph_pkg::ST_S_HIGH: begin
        if (tmr_expired) begin
          next_sck = 1'b0;
          tmr_load = 1'b1;
          tmr_val  = (op == dph_pkg::DPH_OP_READ) ? half_rd : half_wr;
          if (rx_mode) begin
            // panel set this bit at the last falling edge
            next_rx_sh = {rx_sh[30:0], sin_s};
            if (rx_cnt != 6'h00) begin
              next_rx_cnt = rx_cnt - 6'h01;
              next_state  = dph_pkg::ST_S_LOW;
            end else begin
              next_state = dph_pkg::ST_S_END;
            end
          end else if (tx_cnt != 3'h0) begin
            next_sdo    = tx_sh[7];
            next_tx_sh  = {tx_sh[6:0], 1'b0};
            next_tx_cnt = tx_cnt - 3'h1;
            if (tx_cnt == 3'h1) begin
              next_dc = (op == dph_pkg::DPH_OP_READ) ? 1'b0 : is_data;
            end
            next_state = dph_pkg::ST_S_LOW;
          end else if (op == dph_pkg::DPH_OP_READ) begin
            // command sent, reply comes in on serial in
            next_rx_mode = 1'b1;
            next_sdo     = 1'b0;
            next_state   = dph_pkg::ST_S_LOW;
          end else begin
            next_state = dph_pkg::ST_S_END;
          end
        end
      end
      dph_pkg::ST_S_END: begin
        if (tmr_expired) begin
          next_sel_n = 1'b1;
          tmr_load   = 1'b1;
          tmr_val    = half_wr;
          if (op == dph_pkg::DPH_OP_READ) begin
            next_resp_valid = 1'b1;
            next_resp_data  = rx_sh;
          end
          next_state = dph_pkg::ST_DONE;
        end
      end
      dph_pkg::ST_P_WLOW: begin
        if (tmr_expired) begin
          next_wr_n  = 1'b1;
          tmr_load   = 1'b1;
          tmr_val    = phase_len(dph_pkg::WR_HIGH_CYC, phase_stretch);
          next_state = dph_pkg::ST_P_WHIGH;
        end
      end
      dph_pkg::ST_P_WHIGH: begin
        if (tmr_expired) begin
          tmr_load = 1'b1;
          if (op == dph_pkg::DPH_OP_READ) begin
            next_oe    = 1'b0;
            next_rd_n  = 1'b0;
            next_rs    = 1'b1;
            tmr_val    = phase_len(dph_pkg::RD_LOW_CYC, phase_stretch);
            next_state = dph_pkg::ST_P_RLOW;
          end else begin
            next_sel_n = 1'b1;
            tmr_val    = 6'h00;
            next_state = dph_pkg::ST_DONE;
          end
        end
      end
      dph_pkg::ST_P_RLOW: begin
        if (tmr_expired) begin
          next_rd_n       = 1'b1;
          next_resp_data  = {24'h00_0000, pdi_s};
          tmr_load        = 1'b1;
          tmr_val         = phase_len(dph_pkg::RD_HIGH_CYC, phase_stretch);
          next_state      = dph_pkg::ST_P_RHIGH;
        end
      end
      dph_pkg::ST_P_RHIGH: begin
        if (tmr_expired) begin
          next_sel_n      = 1'b1;
          next_resp_valid = 1'b1;
          tmr_load        = 1'b1;
          tmr_val         = 6'h00;
          next_state      = dph_pkg::ST_DONE;
        end
      end
      dph_pkg::ST_DONE: begin
        // select stays high for at least this phase between bytes
        if (tmr_expired) begin
          next_state = dph_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = dph_pkg::ST_IDLE;
      end
    endcase
    next_req_ready = (next_state == dph_pkg::ST_IDLE);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state              <= dph_pkg::ST_IDLE;
      op                 <= dph_pkg::DPH_OP_WRITE;
      is_data            <= 1'b0;
      tx_sh              <= 8'h00;
      tx_cnt             <= 3'h0;
      rx_mode            <= 1'b0;
      rx_cnt             <= 6'h00;
      rx_sh              <= 32'h0000_0000;
      req_ready          <= 1'b0;
      resp_valid         <= 1'b0;
      resp_data          <= 32'h0000_0000;
      panel_reset_n      <= dph_pkg::RST_PANEL_N;
      panel_select_n     <= dph_pkg::RST_SEL_N;
      cmd_data_select    <= 1'b0;
      panel_serial_clock <= dph_pkg::RST_SCK;
      panel_serial_out   <= 1'b0;
      register_select    <= 1'b0;
      write_strobe_n     <= dph_pkg::RST_STROBE_N;
      read_strobe_n      <= dph_pkg::RST_STROBE_N;
      par_data_out       <= 8'h00;
      par_data_oe        <= 1'b0;
    end else begin
      state              <= next_state;
      op                 <= next_op;
      is_data            <= next_is_data;
      tx_sh              <= next_tx_sh;
      tx_cnt             <= next_tx_cnt;
      rx_mode            <= next_rx_mode;
      rx_cnt             <= next_rx_cnt;
      rx_sh              <= next_rx_sh;
      req_ready          <= next_req_ready;
      resp_valid         <= next_resp_valid;
      resp_data          <= next_resp_data;
      panel_reset_n      <= next_panel_reset_n;
      panel_select_n     <= next_sel_n;
      cmd_data_select    <= next_dc;
      panel_serial_clock <= next_sck;
      panel_serial_out   <= next_sdo;
      register_select    <= next_rs;
      write_strobe_n     <= next_wr_n;
      read_strobe_n      <= next_rd_n;
      par_data_out       <= next_pdo;
      par_data_oe        <= next_oe;
    end
  end

endmodule

/* dph_top_bench.sv */
// self-checking bench for the display panel host port
`timescale 1ns/1ps
module dph_top_bench;
  typedef struct packed {
    logic        par;
    logic        rd;
    logic        dat;
    logic [1:0]  rl;
    logic [7:0]  d;
    logic [31:0] v;
  } dph_row_t;

  logic              clk_sys = 1'b0;
  logic              rst = 1'b1;
  logic              mode_parallel = 1'b0;
  logic              panel_reset_hold = 1'b0;
  logic [3:0]        phase_stretch = 4'h0;
  logic              req_valid = 1'b0;
  dph_pkg::dph_req_t req = '0;
  logic [31:0]       reply = 32'h0;
  logic [31:0]       resp_data;
  logic [7:0]        bus, pdo, pdrv, rx_byte, p_byte;
  logic              req_ready, resp_valid, rst_n, sel_n, dc, sck, sdo;
  logic              rs, wr_n, rd_n, oe, sdi, rx_dc, p_rs, got_rv;
  int                error_cnt = 0;
  int                check_count = 0;
  dph_row_t          rows [8] = '{
    '{1'b0, 1'b0, 1'b0, 2'h0, 8'hA5, 32'h0},
    '{1'b0, 1'b0, 1'b1, 2'h0, 8'h3C, 32'h0},
    '{1'b0, 1'b1, 1'b0, 2'h0, 8'h0A, 32'h96},
    '{1'b0, 1'b1, 1'b0, 2'h1, 8'h04, 32'hC35A81},
    '{1'b0, 1'b1, 1'b0, 2'h2, 8'hDA, 32'h8001F00F},
    '{1'b1, 1'b0, 1'b0, 2'h0, 8'h2C, 32'h0},
    '{1'b1, 1'b0, 1'b1, 2'h0, 8'hD2, 32'h0},
    '{1'b1, 1'b1, 1'b0, 2'h0, 8'h0B, 32'h69}};

  always #20 clk_sys = ~clk_sys;
  assign bus = oe ? pdo : pdrv;

  dph_top i_dph_top (.clk_sys(clk_sys), .rst(rst),
    .mode_parallel(mode_parallel), .panel_reset_hold(panel_reset_hold),
    .phase_stretch(phase_stretch), .req_valid(req_valid), .req(req),
    .req_ready(req_ready), .resp_valid(resp_valid), .resp_data(resp_data),
    .panel_reset_n(rst_n), .panel_select_n(sel_n), .cmd_data_select(dc),
    .panel_serial_clock(sck), .panel_serial_out(sdo),
    .panel_serial_in(sdi), .register_select(rs), .write_strobe_n(wr_n),
    .read_strobe_n(rd_n), .par_data_in(bus), .par_data_out(pdo),
    .par_data_oe(oe));

  dph_panel_model i_dph_panel_model (.sck(sck), .sel_n(sel_n), .sdo(sdo),
    .dc(dc), .rs(rs), .wr_n(wr_n), .rd_n(rd_n), .bus(bus), .reply(reply),
    .sdi(sdi), .pdrv(pdrv), .rx_byte(rx_byte), .rx_dc(rx_dc),
    .p_byte(p_byte), .p_rs(p_rs));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
    end
  endtask

  task wrap_up;
    if (error_cnt == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // present one request, hold it until taken, wait for idle again
  task xfer(input dph_row_t w);
    int k;
    k = 0;
    got_rv = 1'b0;
    req <= dph_pkg::dph_req_t'({1'b0, w.rd, w.dat, w.rl, w.d});
    req_valid <= 1'b1;
    do begin
      @(posedge clk_sys);
      k++;
    end while (req_ready !== 1'b1 && k < 50);
    req_valid <= 1'b0;
    do begin
      @(posedge clk_sys);
      k++;
      if (resp_valid === 1'b1) got_rv = 1'b1;
    end while (req_ready !== 1'b1 && k < 1000);
  endtask

  task run(input dph_row_t w);
    mode_parallel <= w.par;
    reply <= (w.par || w.rl == 2'h2) ? w.v : w.v << (w.rl == 2'h0 ? 24 : 8);
    xfer(w);
    if (!w.par) begin
      chk(rx_byte, w.d);
      chk(rx_dc, w.dat & !w.rd);
    end else begin
      chk(p_byte, w.d);
      chk(p_rs, w.dat & !w.rd);
    end
    chk(got_rv, w.rd);
    if (w.rd) begin
      chk(w.par ? resp_data[7:0] : resp_data, w.v);
    end
  endtask

  initial begin
    repeat (20) @(posedge clk_sys);
    chk({req_ready, sel_n, wr_n, rd_n, rst_n, oe}, 6'h1C);
    rst <= 1'b0;
    repeat (2) @(posedge clk_sys);
    for (int i = 0; i < 8; i++) run(rows[i]);
    phase_stretch <= 4'h3;
    run(dph_row_t'{1'b0, 1'b0, 1'b1, 2'h0, 8'h81, 32'h0});
    run(dph_row_t'{1'b0, 1'b1, 1'b0, 2'h0, 8'h04, 32'h5A});
    run(dph_row_t'{1'b1, 1'b1, 1'b0, 2'h0, 8'h11, 32'hE7});
    phase_stretch <= 4'h0;
    panel_reset_hold <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk(rst_n, 1'b0);
    panel_reset_hold <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk(rst_n, 1'b1);
    mode_parallel <= 1'b0;
    req <= dph_pkg::dph_req_t'({3'h1, 2'h0, 8'hC3});
    req_valid <= 1'b1;
    repeat (12) @(posedge clk_sys);
    req_valid <= 1'b0;
    rst <= 1'b1;
    @(posedge clk_sys);
    chk({sel_n, sck, req_ready, rst_n}, 4'h8);
    rst <= 1'b0;
    @(posedge clk_sys);
    run(dph_row_t'{1'b0, 1'b0, 1'b1, 2'h0, 8'h5A, 32'h0});
    wrap_up;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    error_cnt++;
    wrap_up;
  end
endmodule

bind dph_top dph_monitor i_dph_monitor (.clk_sys(clk_sys), .rst(rst),
  .panel_reset_hold(panel_reset_hold), .req_valid(req_valid),
  .req_ready(req_ready), .resp_valid(resp_valid),
  .panel_reset_n(panel_reset_n), .panel_select_n(panel_select_n),
  .panel_serial_clock(panel_serial_clock),
  .panel_serial_out(panel_serial_out), .write_strobe_n(write_strobe_n),
  .read_strobe_n(read_strobe_n), .par_data_out(par_data_out),
  .par_data_oe(par_data_oe));
